// ==== rtl/acp_top.sv ====
`include "acp_params.svh"
// Function
// - strap picks serial or parallel programming
// - chip select low frames serial transfer
// - SDI captured on SCK rising edge
// - open-drain SDO readback, host samples falling
// - parallel: CS pin controls duty stabilizer
// - parallel: SCK pin selects full or differential
// - parallel: SDI high puts device asleep
// - parallel: SDO unused and released
// - conversion starts on encode rising edge
// - full rate: data changes on clock fall
// - complementary clock is inverse of true
// - true clock delay set by second register
// - double rate: even bits low, odd high
// - double rate: data changes both edges
// - differential pairs carry same multiplexing, termination
// - overflow flag travels with its sample
// - serial: second register enables stabilizer
// - serial: third register selects output format
module acp_top (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PROGRAM_STYLE_STRAP,
  input wire logic SAMPLE_STROBE_TRUE,
  input wire logic SAMPLE_STROBE_COMP,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SDI,
  output logic SDO_O,
  output logic SDO_OE,
  input wire logic [13:0] CONV_CODE,
  input wire logic CONV_RANGE_ERR,
  output logic [13:0] SAMPLE_BITS,
  output logic [6:0] PAIRED_SAMPLE_LINES_P,
  output logic [6:0] PAIRED_SAMPLE_LINES_N,
  output logic FWD_CLOCK_TRUE,
  output logic FWD_CLOCK_COMP,
  output logic RANGE_EXCEEDED_FLAG,
  output logic STABILIZER_ON,
  output logic SLEEP,
  output logic TERM_ON,
  output acp_pkg::acp_outmode_t OUT_MODE
);
  import acp_pkg::*;

  typedef struct packed {
    logic [1:0] strap_s;
    logic serial_en;
    logic [1:0] enc_s;
    logic [1:0] encn_s;
    logic enc_d;
    logic [1:0] csn_s;
    logic [1:0] sck_s;
    logic [1:0] sdi_s;
    logic [13:0] hold;
    logic hold_of;
    logic [13:0] bits;
    logic [6:0] pair;
    logic of;
    acp_phase_t ph;
    logic [3:0] dly;
    logic clk_t;
    logic stab;
    logic sleep;
    logic term;
    acp_outmode_t mode;
  } acp_top_st_t;
  acp_top_st_t st_r, st_nxt;

  logic [`ACP_DATA_W-1:0] reg_two, reg_three, reg_four;
  logic sdo_oe_c;

  acp_cfg_port u_cfg (
    .clk(CLOCK),
    .rst_n(RESETN),
    .serial_en(st_r.serial_en),
    .csn_s(st_r.csn_s[1]),
    .sck_s(st_r.sck_s[1]),
    .sdi_s(st_r.sdi_s[1]),
    .sdo_oe(sdo_oe_c),
    .reg_two(reg_two),
    .reg_three(reg_three),
    .reg_four(reg_four)
  );

  function automatic logic [6:0] pick(input logic [13:0] v, input logic odd);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < 7; i++) r[i] = v[2*i + (odd ? 1 : 0)];
    return r;
  endfunction : pick

  function automatic acp_outmode_t fmt(input logic [1:0] f);
    unique case (f)
      `ACP_FMT_DDR_SE: fmt = ACP_OUT_DDR_SE;
      `ACP_FMT_DDR_DIFF: fmt = ACP_OUT_DDR_DIFF;
      default: fmt = ACP_OUT_FULL;
    endcase
  endfunction : fmt

  logic enc_lvl, enc_rise, enc_fall;
  always_comb begin
    st_nxt = st_r;
    st_nxt.strap_s = {st_r.strap_s[0], PROGRAM_STYLE_STRAP};
    // strap low means serial
    st_nxt.serial_en = ~st_r.strap_s[1];
    // each encode pin synced alone, compared only behind the second stage
    st_nxt.enc_s = {st_r.enc_s[0], SAMPLE_STROBE_TRUE};
    st_nxt.encn_s = {st_r.encn_s[0], SAMPLE_STROBE_COMP};
    enc_lvl = st_r.enc_s[1] & ~st_r.encn_s[1];
    st_nxt.enc_d = enc_lvl;
    st_nxt.csn_s = {st_r.csn_s[0], CS_N};
    st_nxt.sck_s = {st_r.sck_s[0], SCK};
    st_nxt.sdi_s = {st_r.sdi_s[0], SDI};
    enc_rise = enc_lvl & ~st_r.enc_d;
    enc_fall = ~enc_lvl & st_r.enc_d;
    if (st_r.serial_en) begin
      st_nxt.stab = reg_two[`ACP_STAB_BIT];
      st_nxt.mode = fmt(reg_three[`ACP_FMT_LSB +: 2]);
      st_nxt.sleep = reg_four[`ACP_SLEEP_BIT];
      st_nxt.term = reg_three[`ACP_TERM_BIT];
    end else begin
      st_nxt.stab = st_r.csn_s[1];
      st_nxt.mode = st_r.sck_s[1] ? ACP_OUT_DDR_DIFF : ACP_OUT_FULL;
      st_nxt.sleep = st_r.sdi_s[1];
      st_nxt.term = 1'b0;
    end
    st_nxt.dly = reg_two[`ACP_DLY_LSB +: 4];
    if (st_r.sleep) begin
      st_nxt.ph = ACP_PH_IDLE;
      st_nxt.clk_t = 1'b0;
    end else if (enc_rise) begin
      // new sample: true clock falls, data of whole word changes
      st_nxt.hold = CONV_CODE;
      st_nxt.hold_of = CONV_RANGE_ERR;
      st_nxt.bits = CONV_CODE;
      st_nxt.of = CONV_RANGE_ERR;
      st_nxt.pair = pick(CONV_CODE, 1'b0);
      st_nxt.ph = ACP_PH_LOW;
      st_nxt.clk_t = 1'b0;
    end else if (enc_fall && st_r.ph == ACP_PH_LOW) begin
      st_nxt.clk_t = 1'b1;
      if (st_r.mode != ACP_OUT_FULL)
        st_nxt.pair = pick(st_r.hold, 1'b1);
      st_nxt.ph = ACP_PH_HIGH;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= '{strap_s: 2'h0, serial_en: 1'b0, enc_s: 2'h0, encn_s: 2'h3, enc_d: 1'b0,
                csn_s: 2'h3, sck_s: 2'h0, sdi_s: 2'h0, hold: 14'h0000, hold_of: 1'b0,
                bits: 14'h0000, pair: 7'h00, of: 1'b0, ph: ACP_PH_IDLE, dly: 4'h0, clk_t: 1'b0,
                stab: 1'b0, sleep: 1'b0, term: 1'b0, mode: ACP_OUT_FULL};
    end else begin
      st_r <= st_nxt;
    end
  end

  // delay line for the forwarded clock, taps in system cycles
  logic [14:0] clk_dl;
  logic fwd_r, fwd_n_r, sdo_oe_r;
  logic [6:0] pn_r;
  // zero taps: clock edge lands in the cycle the data changes
  logic fwd_nxt;
  assign fwd_nxt = (st_r.dly == 4'h0) ? st_nxt.clk_t : clk_dl[st_r.dly - 4'h1];
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      clk_dl <= 15'h0000;
      fwd_r <= 1'b0;
      fwd_n_r <= 1'b1;
      pn_r <= 7'h7f;
      sdo_oe_r <= 1'b0;
    end else begin
      clk_dl <= {clk_dl[13:0], st_nxt.clk_t};
      fwd_r <= fwd_nxt;
      fwd_n_r <= ~fwd_nxt;
      pn_r <= ~st_nxt.pair;
      sdo_oe_r <= sdo_oe_c & st_r.serial_en;
    end
  end

  assign SAMPLE_BITS = st_r.bits;
  assign PAIRED_SAMPLE_LINES_P = st_r.pair;
  assign PAIRED_SAMPLE_LINES_N = pn_r;
  assign FWD_CLOCK_TRUE = fwd_r;
  assign FWD_CLOCK_COMP = fwd_n_r;
  assign RANGE_EXCEEDED_FLAG = st_r.of;
  assign STABILIZER_ON = st_r.stab;
  assign SLEEP = st_r.sleep;
  assign TERM_ON = st_r.term;
  assign OUT_MODE = st_r.mode;
  assign SDO_O = 1'b0;
  assign SDO_OE = sdo_oe_r;
endmodule : acp_top

// ==== rtl/acp_params.svh ====
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH
`define ACP_SAMPLE_W 14
`define ACP_PAIR_W 7
`define ACP_FRAME_W 16
`define ACP_ADDR_W 8
`define ACP_DATA_W 8
`define ACP_REG_TWO 8'h02
`define ACP_REG_THREE 8'h03
`define ACP_REG_FOUR 8'h04
`define ACP_STAB_BIT 0
`define ACP_FMT_LSB 0
`define ACP_DLY_LSB 4
`define ACP_TERM_BIT 2
`define ACP_REG_TWO_RST 8'h00
`define ACP_REG_THREE_RST 8'h00
`define ACP_REG_FOUR_RST 8'h00
`define ACP_SLEEP_BIT 0
`define ACP_FMT_FULL 2'h0
`define ACP_FMT_DDR_SE 2'h1
`define ACP_FMT_DDR_DIFF 2'h2
`endif

// ==== rtl/acp_pkg.sv ====
package acp_pkg;
  typedef enum logic [1:0] {
    ACP_OUT_FULL = 2'h0,
    ACP_OUT_DDR_SE = 2'h1,
    ACP_OUT_DDR_DIFF = 2'h2
  } acp_outmode_t;
  typedef enum logic [2:0] {
    ACP_PH_IDLE = 3'b001,
    ACP_PH_LOW = 3'b010,
    ACP_PH_HIGH = 3'b100
  } acp_phase_t;
endpackage : acp_pkg

// ==== rtl/acp_cfg_port.sv ====
`include "acp_params.svh"
module acp_cfg_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_en,
  input wire logic csn_s,
  input wire logic sck_s,
  input wire logic sdi_s,
  output logic sdo_oe,
  output logic [`ACP_DATA_W-1:0] reg_two,
  output logic [`ACP_DATA_W-1:0] reg_three,
  output logic [`ACP_DATA_W-1:0] reg_four
);
  typedef struct packed {
    logic sck_d;
    logic [4:0] cnt;
    logic [`ACP_FRAME_W-1:0] sh;
    logic [`ACP_DATA_W-1:0] rb;
    logic sdo_oe;
    logic [`ACP_DATA_W-1:0] r2;
    logic [`ACP_DATA_W-1:0] r3;
    logic [`ACP_DATA_W-1:0] r4;
  } acp_cfg_st_t;
  acp_cfg_st_t st_r, st_nxt;

  function automatic logic [`ACP_DATA_W-1:0] rd_sel(input acp_cfg_st_t s,
                                                  input logic [`ACP_ADDR_W-1:0] a);
    unique case (a)
      `ACP_REG_TWO: rd_sel = s.r2;
      `ACP_REG_THREE: rd_sel = s.r3;
      `ACP_REG_FOUR: rd_sel = s.r4;
      default: rd_sel = 8'h00;
    endcase
  endfunction : rd_sel

  logic [`ACP_FRAME_W-1:0] nsh;
  always_comb begin
    st_nxt = st_r;
    nsh = {st_r.sh[`ACP_FRAME_W-2:0], sdi_s};
    st_nxt.sck_d = sck_s;
    if (!serial_en || csn_s) begin
      // idle frame: pins ignored, SDO released
      st_nxt.cnt = 5'h00;
      st_nxt.sdo_oe = 1'b0;
    end else begin
      if (sck_s && !st_r.sck_d) begin
        st_nxt.sh = nsh;
        st_nxt.cnt = st_r.cnt + 5'h01;
        // address byte complete with read flag: latch readback
        if (st_r.cnt == 5'h07 && nsh[7])
          st_nxt.rb = rd_sel(st_r, {1'b0, nsh[6:0]});
        if (st_r.cnt == 5'h0f && !nsh[15]) begin
          unique case ({1'b0, nsh[14:8]})
            `ACP_REG_TWO: st_nxt.r2 = nsh[7:0];
            `ACP_REG_THREE: st_nxt.r3 = nsh[7:0];
            `ACP_REG_FOUR: st_nxt.r4 = nsh[7:0];
            default: st_nxt.r2 = st_r.r2;
          endcase
        end
      end
      if (!sck_s && st_r.sck_d && st_r.cnt >= 5'h08 && st_r.cnt < 5'h10) begin
        // drive low for a zero, release for a one
        st_nxt.sdo_oe = ~st_r.rb[`ACP_DATA_W-1];
        st_nxt.rb = {st_r.rb[`ACP_DATA_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{sck_d: 1'b0, cnt: 5'h00, sh: 16'h0000, rb: 8'h00, sdo_oe: 1'b0,
                r2: `ACP_REG_TWO_RST, r3: `ACP_REG_THREE_RST, r4: `ACP_REG_FOUR_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sdo_oe = st_r.sdo_oe;
  assign reg_two = st_r.r2;
  assign reg_three = st_r.r3;
  assign reg_four = st_r.r4;
endmodule : acp_cfg_port

// ==== tb/acp_chk.sv ====
module acp_chk (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PROGRAM_STYLE_STRAP,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SDI,
  input wire logic SDO_O,
  input wire logic SDO_OE,
  input wire logic [6:0] PAIRED_SAMPLE_LINES_P,
  input wire logic [6:0] PAIRED_SAMPLE_LINES_N,
  input wire logic FWD_CLOCK_TRUE,
  input wire logic FWD_CLOCK_COMP,
  input wire logic STABILIZER_ON,
  input wire logic SLEEP,
  input wire acp_pkg::acp_outmode_t OUT_MODE
);
  timeunit 1ns;
  timeprecision 1ns;
  import acp_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  wire par = PROGRAM_STYLE_STRAP;
  property p_od; SDO_O == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sdo driven high");
  property p_psdo; par [*6] |-> !SDO_OE; endproperty
  a_psdo: assert property (p_psdo) else $error("sdo used in parallel");
  property p_pstab; (par && $stable(CS_N)) [*6] |-> STABILIZER_ON == CS_N; endproperty
  a_pstab: assert property (p_pstab) else $error("stabilizer pin");
  property p_pmode;
    (par && $stable(SCK)) [*6] |-> OUT_MODE == (SCK ? ACP_OUT_DDR_DIFF : ACP_OUT_FULL);
  endproperty
  a_pmode: assert property (p_pmode) else $error("mode pin");
  property p_pslp; (par && $stable(SDI)) [*6] |-> SLEEP == SDI; endproperty
  a_pslp: assert property (p_pslp) else $error("sleep pin");
  property p_cinv; FWD_CLOCK_COMP != FWD_CLOCK_TRUE; endproperty
  a_cinv: assert property (p_cinv) else $error("clock pair");
  property p_ninv; PAIRED_SAMPLE_LINES_N == ~PAIRED_SAMPLE_LINES_P; endproperty
  a_ninv: assert property (p_ninv) else $error("pair inverse");
  property p_hold;
    (!par && CS_N) [*6] |=> $stable(STABILIZER_ON) && $stable(OUT_MODE) && $stable(SLEEP);
  endproperty
  a_hold: assert property (p_hold) else $error("idle change");
endmodule : acp_chk

bind acp_top acp_chk acp_chk_i (.*);

// ==== tb/acp_host.sv ====
module acp_host (
  input wire logic clk,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  wire sdo_line = sdo_oe ? 1'b0 : 1'b1;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic set_pins(input logic c, input logic k, input logic d);
    cs_n = c;
    sck = k;
    sdi = d;
  endtask : set_pins
  // h is the SCK high time in clk cycles; SCK stays low for 2h
  task automatic xfer(input logic [15:0] f, input int h, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      sdi = f[k];
      repeat (h) @(negedge clk);
      sck = 1'b1;
      repeat (h) @(negedge clk);
      // a bit stands from the previous fall up to this one
      rd = {rd[6:0], sdo_line};
      sck = 1'b0;
      repeat (h) @(negedge clk);
    end
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (h) @(negedge clk);
  endtask : xfer
endmodule : acp_host

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import acp_pkg::*;
  logic clock, resetn, strap, enc, rerr;
  logic [13:0] code, bits;
  logic [6:0] pp, pn;
  logic sdo_o, sdo_oe, ft, fc, ovf, stab, slp, term;
  acp_outmode_t mode;
  wire cs_n, sck, sdi;
  int mismatches = 0;
  int n_tests = 0;
  acp_host acp_host_i (.clk(clock), .sdo_oe(sdo_oe), .cs_n(cs_n), .sck(sck), .sdi(sdi));
  acp_top acp_top_i (.CLOCK(clock), .RESETN(resetn), .PROGRAM_STYLE_STRAP(strap),
    .SAMPLE_STROBE_TRUE(enc), .SAMPLE_STROBE_COMP(!enc), .CS_N(cs_n), .SCK(sck),
    .SDI(sdi), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .CONV_CODE(code), .CONV_RANGE_ERR(rerr),
    .SAMPLE_BITS(bits), .PAIRED_SAMPLE_LINES_P(pp), .PAIRED_SAMPLE_LINES_N(pn),
    .FWD_CLOCK_TRUE(ft), .FWD_CLOCK_COMP(fc), .RANGE_EXCEEDED_FLAG(ovf),
    .STABILIZER_ON(stab), .SLEEP(slp), .TERM_ON(term), .OUT_MODE(mode));
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [13:0] e, input logic [13:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask : w
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rd;
    acp_host_i.xfer({1'b0, a, d}, 4, rd);
    w(8);
  endtask : wr
  function automatic logic [13:0] pick(input logic [13:0] v, input int o);
    pick = 14'h0;
    for (int i = 0; i < 7; i++)
      pick[i] = v[2 * i + o];
  endfunction : pick
  task automatic t_par;
    strap = 1'b1;
    for (int i = 0; i < 8; i++) begin
      acp_host_i.set_pins(i[0], i[1], i[2]);
      w(8);
      chk("stab", 14'(i[0]), 14'(stab));
      chk("mode", 14'(i[1] ? ACP_OUT_DDR_DIFF : ACP_OUT_FULL), 14'(mode));
      chk("sleep", 14'(i[2]), 14'(slp));
      chk("sdo term", 14'h0, {12'h0, sdo_oe, term});
    end
    $display("t_par done");
  endtask : t_par
  task automatic t_ser;
    logic [7:0] rd;
    acp_host_i.set_pins(1'b1, 1'b0, 1'b0);
    strap = 1'b0;
    w(8);
    wr(7'h02, 8'h01);
    chk("stab", 14'h1, 14'(stab));
    for (int f = 0; f < 3; f++) begin
      wr(7'h03, 8'(f));
      chk("mode", 14'(f), 14'(mode));
    end
    wr(7'h03, 8'h06);
    chk("term", 14'h1, 14'(term));
    acp_host_i.xfer({1'b1, 7'h03, 8'h00}, 13, rd);
    chk("readback", 14'h6, 14'(rd));
    acp_host_i.xfer({1'b1, 7'h10, 8'h00}, 13, rd);
    chk("unmapped", 14'h0, 14'(rd));
    for (int k = 0; k < 16; k++) begin
      acp_host_i.set_pins(1'b1, k[0], k[1]);
      w(4);
    end
    acp_host_i.set_pins(1'b1, 1'b0, 1'b1);
    w(8);
    chk("idle", 14'hb, {10'h0, mode, stab, term});
    wr(7'h02, 8'h00);
    chk("stab", 14'h0, 14'(stab));
    $display("t_ser done");
  endtask : t_ser
  task automatic t_full;
    logic [13:0] c;
    wr(7'h03, 8'h00);
    for (int s = 0; s < 2; s++) begin
      c = s ? 14'h12a5 : 14'h2d5a;
      code = c;
      rerr = (s == 0);
      enc = 1'b1;
      w(10);
      chk("bits", c, bits);
      chk("ovf", 14'(s == 0), 14'(ovf));
      chk("clk lo", 14'h1, {12'h0, ft, fc});
      enc = 1'b0;
      w(10);
      chk("clk hi", 14'h2, {12'h0, ft, fc});
    end
    $display("t_full done");
  endtask : t_full
  task automatic t_dly;
    int n;
    for (int d = 0; d < 4; d += 3) begin
      wr(7'h02, 8'(d * 16));
      code = d ? 14'h0b0b : 14'h3070;
      enc = 1'b1;
      n = 0;
      while (bits !== code && n < 20) begin
        w(1);
        n++;
      end
      n = 0;
      while (ft !== 1'b0 && n < 20) begin
        w(1);
        n++;
      end
      chk("clk delay", 14'(d), 14'(n));
      enc = 1'b0;
      w(10);
    end
    $display("t_dly done");
  endtask : t_dly
  task automatic t_ddr;
    for (int m = 1; m < 3; m++) begin
      wr(7'h03, 8'(m));
      code = 14'h3c96;
      rerr = 1'b0;
      enc = 1'b1;
      w(10);
      chk("even", pick(14'h3c96, 0), 14'(pp));
      chk("clk lo", 14'h1, {12'h0, ft, fc});
      enc = 1'b0;
      w(10);
      chk("odd", pick(14'h3c96, 1), 14'(pp));
      chk("pair n", {7'h0, ~pp}, 14'(pn));
      chk("clk hi", 14'h2, {12'h0, ft, fc});
    end
    $display("t_ddr done");
  endtask : t_ddr
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200us;
    mismatches++;
    summarize();
  end
  initial begin
    resetn = 1'b0;
    strap = 1'b1;
    enc = 1'b0;
    rerr = 1'b0;
    code = 14'h0;
    w(16);
    chk("reset", 14'h1, {12'h0, ft, fc});
    resetn = 1'b1;
    w(4);
    t_par();
    t_ser();
    t_full();
    t_ddr();
    t_dly();
    summarize();
  end
endmodule : tb_top
